//--- core/ffrc_fifo_flags.sv
// FIFO storage with status flags, master and partial reset, mode capture and offset registers.
module ffrc_fifo_flags #(
    parameter int DEPTH = 1024
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire ffrc_pkg::ffrc_cfg_pins_t cfg_pins,
    input wire logic offset_load_n,
    input wire logic first_word_fallthrough_mode_si,
    input wire logic serial_enable_n,
    input wire logic write_enable_n,
    input wire logic [ffrc_pkg::DATA_W-1:0] write_data,
    input wire logic read_enable_n,
    input wire logic read_select_n,
    input wire logic output_enable_n,
    input wire logic mark,
    input wire logic retransmit_n,
    output logic [ffrc_pkg::DATA_W-1:0] read_data,
    output logic read_data_oe_n,
    output logic empty_flag_n,
    output logic full_flag_input_ready_n,
    output logic half_full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic read_enable_echo,
    output ffrc_pkg::ffrc_mode_t mode
);
    import ffrc_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW:0] HALF_CNT = (AW + 1)'(DEPTH / 2);
    localparam logic [AW:0] PTR_ONE = (AW + 1)'(1);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff, rd_ptr_ff, mark_ptr_ff, count, free_cnt, retx_target;
    logic mark_valid_ff, valid_ff, ofs_wsel_ff, ofs_rsel_ff;
    logic echo_ff, rcs_ff, pae_sync_ff, paf_sync_ff, pae_raw, paf_raw;
    logic [SUB_W-1:0] wr_sub_ff, rd_sub_ff, wr_last, rd_last, wr_lane, rd_lane;
    logic [5:0] wr_bits, rd_bits, wr_shift, rd_shift;
    logic [DATA_W-1:0] pack_ff, nxt_pack, out_ff, wr_mask, rd_mask, rd_slice;
    ffrc_state_t state_ff, nxt_state;
    ffrc_offsets_t ofs_ff;
    logic soft_reset, empty, full, eff_empty, mem_wr_act, store, ren_act, retx, fetch, rd_adv;
    logic ofs_wr, ofs_rd, ser_shift;

    default clocking main_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    ffrc_mode_latch u_mode_latch (
        .ref_clk(ref_clk),
        .rst(rst),
        .master_reset_n(master_reset_n),
        .cfg_pins(cfg_pins),
        .offset_load_n(offset_load_n),
        .first_word_fallthrough_mode_si(first_word_fallthrough_mode_si),
        .mode(mode)
    );

    // ************************************************************
    // Access decode
    // ************************************************************
    // Either reset clears the data path; only master reset touches modes and offsets.
    assign soft_reset = !master_reset_n || !partial_reset_n;
    assign count = wr_ptr_ff - rd_ptr_ff;
    assign free_cnt = DEPTH_CNT - count;
    assign empty = (count == '0);
    assign full = (count == DEPTH_CNT);
    // A retransmit holds the storage empty for one cycle while the pointer settles.
    assign eff_empty = empty || (state_ff != FFRC_ST_RUN);
    assign mem_wr_act = !write_enable_n && offset_load_n && !soft_reset && !full;
    assign ren_act = !read_enable_n && !read_select_n && offset_load_n && !soft_reset;
    assign ofs_wr = !write_enable_n && !offset_load_n && !soft_reset && !mode.prog_serial;
    assign ofs_rd = !read_enable_n && !read_select_n && !offset_load_n && !soft_reset;
    // Serial loading is held off during partial reset so the programmed offsets survive it.
    assign ser_shift = master_reset_n && partial_reset_n && mode.prog_serial && !serial_enable_n;
    assign retx = !retransmit_n && (state_ff == FFRC_ST_RUN) && !soft_reset;
    assign store = mem_wr_act && (wr_sub_ff == wr_last);
    assign fetch = !eff_empty && !retx && (mode.first_word_fallthrough_mode ? (!valid_ff || ren_act) : ren_act);
    assign rd_adv = fetch && (rd_sub_ff == rd_last);
    assign retx_target = mark_valid_ff ? mark_ptr_ff : '0;

    // ************************************************************
    // Bus matching: narrow pieces pack into and unpack from 36-bit words
    // ************************************************************
    // Big-endian sends the high piece first; the product fits six bits for every width.
    always_comb begin
        wr_last = ffrc_last_piece(mode.wr_width);
        rd_last = ffrc_last_piece(mode.rd_width);
        wr_bits = ffrc_piece_bits(mode.wr_width);
        rd_bits = ffrc_piece_bits(mode.rd_width);
        wr_lane = mode.little_endian ? wr_sub_ff : wr_last - wr_sub_ff;
        rd_lane = mode.little_endian ? rd_sub_ff : rd_last - rd_sub_ff;
        wr_shift = 6'(wr_lane * wr_bits);
        rd_shift = 6'(rd_lane * rd_bits);
        wr_mask = {DATA_W{1'b1}} >> (6'(DATA_W) - wr_bits);
        rd_mask = {DATA_W{1'b1}} >> (6'(DATA_W) - rd_bits);
        nxt_pack = (pack_ff & ~(wr_mask << wr_shift)) | ((write_data & wr_mask) << wr_shift);
        rd_slice = (mem[rd_ptr_ff[AW-1:0]] >> rd_shift) & rd_mask;
    end

    // Storage array has no reset; the pointers alone define its contents.
    always_ff @(posedge ref_clk) begin
        if (store) begin
            mem[wr_ptr_ff[AW-1:0]] <= nxt_pack;
        end
    end

    // Partial write word assembly.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pack_ff <= '0;
            wr_sub_ff <= '0;
        end else if (soft_reset) begin
            pack_ff <= '0;
            wr_sub_ff <= '0;
        end else if (mem_wr_act) begin
            pack_ff <= nxt_pack;
            wr_sub_ff <= store ? '0 : wr_sub_ff + 2'h1;
        end
    end

    // ************************************************************
    // Pointers, mark and sequencing
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
        end else if (soft_reset) begin
            wr_ptr_ff <= '0;
        end else if (store) begin
            wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
        end
    end

    // Retransmit wins over a read in the same cycle; the write side is left alone.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ptr_ff <= '0;
            rd_sub_ff <= '0;
        end else if (soft_reset) begin
            rd_ptr_ff <= '0;
            rd_sub_ff <= '0;
        end else if (retx) begin
            rd_ptr_ff <= retx_target;
            rd_sub_ff <= '0;
        end else if (fetch) begin
            rd_ptr_ff <= rd_adv ? rd_ptr_ff + PTR_ONE : rd_ptr_ff;
            rd_sub_ff <= rd_adv ? '0 : rd_sub_ff + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mark_ptr_ff <= '0;
            mark_valid_ff <= 1'b0;
        end else if (soft_reset) begin
            mark_valid_ff <= 1'b0;
        end else if (mark) begin
            mark_ptr_ff <= rd_ptr_ff;
            mark_valid_ff <= 1'b1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FFRC_ST_RESET: nxt_state = FFRC_ST_RUN;
            FFRC_ST_RUN: if (retx) begin
                nxt_state = FFRC_ST_RETX;
            end
            FFRC_ST_RETX: nxt_state = FFRC_ST_RUN;
            default: nxt_state = FFRC_ST_RESET;
        endcase
        if (soft_reset) begin
            nxt_state = FFRC_ST_RESET;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= FFRC_ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ************************************************************
    // Offset registers
    // ************************************************************
    // Master reset reloads the preset; partial reset leaves the offsets as programmed.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ofs_ff <= '0;
        end else if (!master_reset_n) begin
            ofs_ff.full_ofs <= DEF_OFS[ffrc_default_index(offset_load_n, cfg_pins)];
            ofs_ff.empty_ofs <= DEF_OFS[ffrc_default_index(offset_load_n, cfg_pins)];
        end else if (ser_shift) begin
            ofs_ff <= {first_word_fallthrough_mode_si, ofs_ff[2*OFS_W-1:1]};
        end else if (ofs_wr && ofs_wsel_ff) begin
            ofs_ff.full_ofs <= write_data[OFS_W-1:0];
        end else if (ofs_wr) begin
            ofs_ff.empty_ofs <= write_data[OFS_W-1:0];
        end
    end

    // Parallel accesses alternate empty offset first, then full offset.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ofs_wsel_ff <= 1'b0;
            ofs_rsel_ff <= 1'b0;
        end else if (soft_reset) begin
            ofs_wsel_ff <= 1'b0;
            ofs_rsel_ff <= 1'b0;
        end else begin
            ofs_wsel_ff <= ofs_wsel_ff ^ ofs_wr;
            ofs_rsel_ff <= ofs_rsel_ff ^ ofs_rd;
        end
    end

    // ************************************************************
    // Output register, valid and three-state control
    // ************************************************************
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_ff <= '0;
        end else if (soft_reset) begin
            out_ff <= '0;
        end else if (fetch) begin
            out_ff <= rd_slice;
        end else if (ofs_rd) begin
            out_ff <= DATA_W'(ofs_rsel_ff ? ofs_ff.full_ofs : ofs_ff.empty_ofs);
        end
    end

    // Fall-through valid: the head word sits in the output register until consumed.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            valid_ff <= 1'b0;
        end else if (soft_reset || retx) begin
            valid_ff <= 1'b0;
        end else if (fetch) begin
            valid_ff <= 1'b1;
        end else if (ren_act) begin
            valid_ff <= 1'b0;
        end
    end

    // Chip select is sampled, output enable is not, so the enable acts without the clock.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rcs_ff <= 1'b1;
            echo_ff <= 1'b0;
        end else begin
            rcs_ff <= read_select_n;
            echo_ff <= mode.rd_sync && ren_act;
        end
    end

    assign read_data = out_ff;
    assign read_data_oe_n = output_enable_n || (!soft_reset && rcs_ff);
    assign read_enable_echo = echo_ff;

    // ************************************************************
    // Flags
    // ************************************************************
    assign empty_flag_n = mode.first_word_fallthrough_mode ? !valid_ff : !eff_empty;
    assign full_flag_input_ready_n = mode.first_word_fallthrough_mode ? full : !full;
    assign half_full_flag_n = !(count > HALF_CNT);
    assign pae_raw = OFS_W'(count) >= ofs_ff.empty_ofs;
    assign paf_raw = OFS_W'(free_cnt) > ofs_ff.full_ofs;

    // Synchronous flag mode trades one cycle of latency for glitch-free almost-empty and almost-full flags.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pae_sync_ff <= 1'b0;
            paf_sync_ff <= 1'b1;
        end else begin
            pae_sync_ff <= pae_raw;
            paf_sync_ff <= paf_raw;
        end
    end

    assign almost_empty_flag_n = mode.flag_sync ? pae_sync_ff : pae_raw;
    assign almost_full_flag_n = mode.flag_sync ? paf_sync_ff : paf_raw;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence retx_taken_s;
        !retransmit_n && state_ff == FFRC_ST_RUN && !soft_reset;
    endsequence

    echo_async_a: assert property (!mode.rd_sync |=> !read_enable_echo)
        else $error("read enable echo active with asynchronous read port");
    full_pin_a: assert property (!mode.first_word_fallthrough_mode |-> full_flag_input_ready_n == (count != DEPTH_CNT))
        else $error("full flag does not match storage level");
    half_full_a: assert property (half_full_flag_n == (count <= HALF_CNT))
        else $error("half-full flag wrong");
    ptr_clear_a: assert property (!master_reset_n |=> rd_ptr_ff == '0 && wr_ptr_ff == '0 && read_data == '0)
        else $error("master reset left pointers or output set");
    retx_reload_a: assert property (retx_taken_s |=> rd_ptr_ff == $past(retx_target)
                                    && (mode.first_word_fallthrough_mode || !empty_flag_n))
        else $error("retransmit did not reload pointer or force empty");
    mark_keep_a: assert property (mark && !soft_reset |=> mark_valid_ff && mark_ptr_ff == $past(rd_ptr_ff))
        else $error("mark did not record read pointer");
    oe_reset_a: assert property (soft_reset |-> read_data_oe_n == output_enable_n)
        else $error("output enable not sole control during reset");
    pae_level_a: assert property (!mode.flag_sync |-> almost_empty_flag_n == (OFS_W'(count) >= ofs_ff.empty_ofs))
        else $error("almost-empty flag wrong");
    paf_level_a: assert property (mode.flag_sync ##1 mode.flag_sync |->
        almost_full_flag_n == (OFS_W'($past(free_cnt)) > $past(ofs_ff.full_ofs)))
        else $error("almost-full flag wrong");
    ofs_keep_a: assert property (master_reset_n && !partial_reset_n |=> $stable(ofs_ff))
        else $error("partial reset disturbed offsets");
    ofs_default_a: assert property ($rose(master_reset_n) |-> ofs_ff.empty_ofs == DEF_OFS[mode.def_sel])
        else $error("default offset not loaded");

endmodule

//--- core/ffrc_mode_latch.sv
// Mode register that follows the configuration pins during master reset and holds them afterwards.
module ffrc_mode_latch (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic master_reset_n,
    input wire ffrc_pkg::ffrc_cfg_pins_t cfg_pins,
    input wire logic offset_load_n,
    input wire logic first_word_fallthrough_mode_si,
    output ffrc_pkg::ffrc_mode_t mode
);
    import ffrc_pkg::*;

    ffrc_mode_t mode_ff;
    ffrc_mode_t nxt_mode;

    default clocking mode_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Decode the pins into mode fields every cycle of master reset.
    always_comb begin
        nxt_mode.first_word_fallthrough_mode = first_word_fallthrough_mode_si && cfg_pins.read_port_sync;
        nxt_mode.prog_serial = offset_load_n;
        nxt_mode.def_sel = ffrc_default_index(offset_load_n, cfg_pins);
        nxt_mode.wr_width = ffrc_width_of(cfg_pins.bus_matching_enable, cfg_pins.write_port_width_sel,
                                          cfg_pins.read_port_width_sel, 1'b1);
        nxt_mode.rd_width = ffrc_width_of(cfg_pins.bus_matching_enable, cfg_pins.write_port_width_sel,
                                          cfg_pins.read_port_width_sel, 1'b0);
        nxt_mode.rd_sync = cfg_pins.read_port_sync;
        nxt_mode.wr_sync = cfg_pins.write_port_sync;
        nxt_mode.little_endian = cfg_pins.little_endian;
        nxt_mode.zero_latency = cfg_pins.zero_latency;
        nxt_mode.interspersed = cfg_pins.parity_placement_select;
        nxt_mode.flag_sync = cfg_pins.flag_timing_select;
    end

    // Follow while master reset is low, so the value at its release is the one kept.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_ff <= '0;
        end else if (!master_reset_n) begin
            mode_ff <= nxt_mode;
        end
    end

    assign mode = mode_ff;

    mode_hold_a: assert property (master_reset_n && $past(master_reset_n) |-> $stable(mode_ff))
        else $error("mode changed outside master reset");

    first_word_fallthrough_mode_capture_a: assert property ($rose(master_reset_n) && $past(cfg_pins.read_port_sync)
                                     |-> mode_ff.first_word_fallthrough_mode == $past(first_word_fallthrough_mode_si))
        else $error("timing mode not taken from the pin at reset release");

    width_map_a: assert property ($rose(master_reset_n) && !$past(cfg_pins.bus_matching_enable)
                                  |-> mode_ff.wr_width == FFRC_W36 && mode_ff.rd_width == FFRC_W36)
        else $error("bus matching off did not give both ports full width");

    parity_capture_a: assert property ($rose(master_reset_n)
                                       |-> mode_ff.interspersed == $past(cfg_pins.parity_placement_select))
        else $error("parity placement not captured");

endmodule

//--- core/ffrc_pkg.sv
// Shared types, constants and decode functions of the FIFO flag, mode and reset block.
package ffrc_pkg;

    // ************************************************************
    // Widths and default offsets
    // ************************************************************
    localparam int DATA_W = 36;
    localparam int OFS_W = 16;
    localparam int SUB_W = 2;
    localparam int NUM_DEFAULTS = 8;

    // Eight preset offsets, indexed by {offset_load_enable, sel_1, sel_0}.
    localparam logic [OFS_W-1:0] DEF_OFS [NUM_DEFAULTS] = '{
        16'h0007, 16'h000F, 16'h001F, 16'h003F, 16'h007F, 16'h00FF, 16'h01FF, 16'h03FF
    };

    // Pieces per stored word, as last piece index, and bits per piece.
    localparam logic [SUB_W-1:0] LAST_PIECE_36 = 2'h0;
    localparam logic [SUB_W-1:0] LAST_PIECE_18 = 2'h1;
    localparam logic [SUB_W-1:0] LAST_PIECE_9 = 2'h3;
    localparam logic [5:0] PIECE_BITS_36 = 6'h24;
    localparam logic [5:0] PIECE_BITS_18 = 6'h12;
    localparam logic [5:0] PIECE_BITS_9 = 6'h09;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        FFRC_W36 = 2'h0,
        FFRC_W18 = 2'h1,
        FFRC_W9 = 2'h2
    } ffrc_width_t;

    // Gray path: reset -> run -> retransmit -> run.
    typedef enum logic [1:0] {
        FFRC_ST_RESET = 2'h0,
        FFRC_ST_RUN = 2'h1,
        FFRC_ST_RETX = 2'h3
    } ffrc_state_t;

    // Configuration pins sampled while master reset is held.
    typedef struct packed {
        logic bus_matching_enable;
        logic write_port_width_sel;
        logic read_port_width_sel;
        logic default_offset_sel_1;
        logic default_offset_sel_0;
        logic parity_placement_select;
        logic flag_timing_select;
        logic read_port_sync;
        logic write_port_sync;
        logic little_endian;
        logic zero_latency;
    } ffrc_cfg_pins_t;

    // Mode settings held from the end of one master reset to the next.
    typedef struct packed {
        logic first_word_fallthrough_mode;
        logic prog_serial;
        logic [2:0] def_sel;
        ffrc_width_t wr_width;
        ffrc_width_t rd_width;
        logic rd_sync;
        logic wr_sync;
        logic little_endian;
        logic zero_latency;
        logic interspersed;
        logic flag_sync;
    } ffrc_mode_t;

    typedef struct packed {
        logic [OFS_W-1:0] full_ofs;
        logic [OFS_W-1:0] empty_ofs;
    } ffrc_offsets_t;

    // ************************************************************
    // Decode functions
    // ************************************************************
    // Port width from the bus-matching pins, for the write or the read side.
    function automatic ffrc_width_t ffrc_width_of(input logic bm, input logic iw, input logic ow,
                                                  input logic is_write);
        ffrc_width_t narrow;
        narrow = ow ? FFRC_W9 : FFRC_W18;
        if (!bm) begin
            return FFRC_W36;
        end
        if (is_write) begin
            return iw ? narrow : FFRC_W36;
        end
        return iw ? FFRC_W36 : narrow;
    endfunction

    function automatic logic [SUB_W-1:0] ffrc_last_piece(input ffrc_width_t w);
        case (w)
            FFRC_W18: return LAST_PIECE_18;
            FFRC_W9: return LAST_PIECE_9;
            default: return LAST_PIECE_36;
        endcase
    endfunction

    function automatic logic [5:0] ffrc_piece_bits(input ffrc_width_t w);
        case (w)
            FFRC_W18: return PIECE_BITS_18;
            FFRC_W9: return PIECE_BITS_9;
            default: return PIECE_BITS_36;
        endcase
    endfunction

    function automatic logic [2:0] ffrc_default_index(input logic ld, input ffrc_cfg_pins_t p);
        return {ld, p.default_offset_sel_1, p.default_offset_sel_0};
    endfunction

endpackage

//--- tb/ffrc_fifo_flags_tb.sv
// Self-checking testbench for the FIFO flag, mode and reset block.
module ffrc_fifo_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ffrc_pkg::*;
    logic ref_clk = 0, rst = 1, master_reset_n = 0, offset_load_n = 0, read_enable_n = 1;
    logic read_select_n = 1, output_enable_n = 0, partial_reset_n = 1, serial_enable_n = 1;
    logic mark = 0, retransmit_n = 1, first_word_fallthrough_mode_si = 0, write_enable_n;
    logic [35:0] write_data, read_data;
    logic oe_n, ef_n, ff_n, hf_n, ae_n, af_n, echo;
    ffrc_cfg_pins_t cfg = '0;
    ffrc_mode_t mode;
    int err_total = 0;
    int comparisons = 0;

    // ****************************************
    // Clock, partner and design
    // ****************************************
    always #4 ref_clk = ~ref_clk;
    ffrc_writer pw (.ref_clk(ref_clk), .write_enable_n(write_enable_n), .write_data(write_data));
    ffrc_fifo_flags #(.DEPTH(16)) dut (.ref_clk(ref_clk), .rst(rst), .master_reset_n(master_reset_n),
        .partial_reset_n(partial_reset_n), .cfg_pins(cfg), .offset_load_n(offset_load_n), .first_word_fallthrough_mode_si(first_word_fallthrough_mode_si),
        .serial_enable_n(serial_enable_n), .write_enable_n(write_enable_n), .write_data(write_data),
        .read_enable_n(read_enable_n), .read_select_n(read_select_n), .output_enable_n(output_enable_n),
        .mark(mark), .retransmit_n(retransmit_n), .read_data(read_data), .read_data_oe_n(oe_n),
        .empty_flag_n(ef_n), .full_flag_input_ready_n(ff_n), .half_full_flag_n(hf_n),
        .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n), .read_enable_echo(echo), .mode(mode));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Pushes n words, then lets the flags settle for two edges.
    task automatic push(input int n);
        pw.send(n);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // Modes are captured from the pins held during master reset and kept afterwards.
    task automatic scn_reset_modes();
        repeat (2) @(posedge ref_clk);
        #1 master_reset_n = 1'b1;
        offset_load_n = 1'b1;
        cfg = '1;
        repeat (2) @(posedge ref_clk);
        #1 chk("interspersed", mode.interspersed, 1'b1);
        chk("flag_sync", mode.flag_sync, 1'b0);
        chk("rd_sync", mode.rd_sync, 1'b1);
        chk("def_sel", mode.def_sel, 3'h0);
        chk("prog_serial", mode.prog_serial, 1'b0);
        chk("first_word_fallthrough_mode", mode.first_word_fallthrough_mode, 1'b0);
        chk("wr_width", mode.wr_width, FFRC_W36);
        chk("read_data", read_data, 36'h0);
        chk("empty", ef_n, 1'b0);
    endtask

    // Fill across each flag boundary with the default offset of seven words.
    task automatic scn_fill_flags();
        push(6);
        chk("ae_at_6", ae_n, 1'b0);
        push(1);
        chk("ae_at_7", ae_n, 1'b1);
        push(1);
        chk("hf_at_8", hf_n, 1'b1);
        chk("af_at_8", af_n, 1'b1);
        push(1);
        chk("hf_at_9", hf_n, 1'b0);
        chk("af_at_9", af_n, 1'b0);
        chk("ff_at_9", ff_n, 1'b1);
        push(7);
        chk("ff_at_16", ff_n, 1'b0);
    endtask

    // A synchronous read returns the first word, echoes the enable and frees space.
    task automatic scn_read_echo();
        read_enable_n = 1'b0;
        read_select_n = 1'b0;
        @(posedge ref_clk);
        #1 read_enable_n = 1'b1;
        chk("read_data", read_data, 36'h1);
        chk("echo", echo, 1'b1);
        @(posedge ref_clk);
        #1 chk("echo_low", echo, 1'b0);
        chk("ff_after_read", ff_n, 1'b1);
        output_enable_n = 1'b1;
        #1 chk("oe_off", oe_n, 1'b1);
    endtask

    // Mark, retransmit, partial reset, then a second master reset into fall-through with synchronous flags.
    task automatic scn_mark_retx_modes();
        @(posedge ref_clk);
        #1 mark = 1'b1;
        @(posedge ref_clk);
        #1 mark = 1'b0;
        read_enable_n = 1'b0;
        @(posedge ref_clk);
        #1 chk("read_2", read_data, 36'h2);
        retransmit_n = 1'b0;
        @(posedge ref_clk);
        #1 retransmit_n = 1'b1;
        chk("ef_retx", ef_n, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1 read_enable_n = 1'b1;
        chk("replay", read_data, 36'h2);
        partial_reset_n = 1'b0;
        @(posedge ref_clk);
        #1 partial_reset_n = 1'b1;
        chk("prs_data", read_data, 36'h0);
        chk("prs_empty", ef_n, 1'b0);
        master_reset_n = 1'b0;
        offset_load_n = 1'b0;
        first_word_fallthrough_mode_si = 1'b1;
        cfg = '{flag_timing_select: 1'b1, read_port_sync: 1'b1, default: 1'b0};
        repeat (2) @(posedge ref_clk);
        #1 master_reset_n = 1'b1;
        offset_load_n = 1'b1;
        first_word_fallthrough_mode_si = 1'b0;
        chk("first_word_fallthrough_mode_on", mode.first_word_fallthrough_mode, 1'b1);
        chk("ir_space", ff_n, 1'b0);
        pw.send(8);
        chk("ae_lag", ae_n, 1'b0);
        chk("ft_word", read_data, 36'h11);
        chk("or_low", ef_n, 1'b0);
        read_enable_n = 1'b0;
        @(posedge ref_clk);
        #1 read_enable_n = 1'b1;
        chk("ae_sync", ae_n, 1'b1);
        chk("ft_next", read_data, 36'h12);
    endtask

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        cfg.parity_placement_select = 1'b1;
        cfg.read_port_sync = 1'b1;
        cfg.write_port_sync = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        scn_reset_modes();
        scn_fill_flags();
        scn_read_echo();
        scn_mark_retx_modes();
        test_done();
    end
endmodule

//--- tb/ffrc_writer.sv
// Writing-side partner model that pushes counted words into the FIFO.
module ffrc_writer (
    input wire logic ref_clk,
    output logic write_enable_n,
    output logic [35:0] write_data
);
    timeunit 1ns;
    timeprecision 100ps;
    int next_val = 1;

    // One word per edge; data is inverted once released so stale values are never trusted.
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            write_enable_n = 1'b0;
            write_data = 36'(next_val);
            next_val++;
            @(posedge ref_clk);
            #1;
        end
        write_enable_n = 1'b1;
        write_data = ~write_data;
    endtask

    initial begin
        write_enable_n = 1'b1;
        write_data = 36'h0;
    end
endmodule
